// *** hdl/rcr_pkg.sv ***
package rcr_pkg;
    // register addresses
    localparam logic [7:0] RUN_ADDR      = 8'h02;
    localparam logic [7:0] LEVEL_ADDR    = 8'h03;
    localparam logic [7:0] SWCFG_ADDR    = 8'h05;
    // reset values
    localparam logic [7:0] RUN_RST       = 8'h08;
    localparam logic [7:0] LEVEL_RST     = 8'h5C;
    localparam logic [7:0] SWCFG_RST     = 8'h45;
    // writable bits of the run register
    localparam logic [7:0] RUN_WMASK     = 8'h0D;
    // peripheral address on the serial bus
    localparam logic [6:0] PERIPH_ADDR   = 7'h6A;
    // output level encoding: millivolts
    localparam logic [7:0] LEVEL_MAX     = 8'hB4;
    localparam int         BASE_MV       = 1000;
    localparam int         STEP_MV       = 25;
    localparam logic [12:0] SAT_MV       = 13'h157C;
    // field positions in the switching config register
    localparam int FFS_BIT   = 7;
    localparam int FSU_BIT   = 6;
    localparam int BLEED_LO  = 4;
    localparam int FLOOR_BIT = 3;
    localparam int SSD_LO    = 0;
    // field positions in the run register
    localparam int QVS_BIT   = 3;
    localparam int HIC_BIT   = 2;
    localparam int RUN_BIT   = 0;

    typedef enum logic [2:0] {
        RCR_IDLE  = 3'b000,
        RCR_ADDR  = 3'b001,
        RCR_AACK  = 3'b011,
        RCR_REG   = 3'b010,
        RCR_RACK  = 3'b110,
        RCR_DATA  = 3'b111,
        RCR_DACK  = 3'b101,
        RCR_RD    = 3'b100
    } rcr_state_t;

    // decoded control outputs
    typedef struct packed {
        logic       converter_run;
        logic       quick_voltage_step_enable;
        logic       hiccup_protect_enable;
        logic       forced_fixed_freq_switching;
        logic       fast_startup_enable;
        logic [1:0] output_bleed_strength;
        logic       startup_current_floor;
        logic [2:0] softstart_duration_sel;
    } rcr_ctrl_t;
endpackage : rcr_pkg

// *** hdl/rcr_regs.sv ***
`timescale 1ns/1ps
// Behaviour
// - run register bits 7:4,1 read zero
// - bit3 quick step enable, resets one
// - bit2 hiccup protect enable, resets zero
// - bit0 run, ANDed with enable pin
// - level register eight bits, resets 5C
// - codes to B4: 1000 mV plus 25 mV steps
// - codes above B4 saturate 5500 mV
// - config bit7 forced fixed frequency
// - config bit6 fast startup, resets one
// - config bits5:4 bleed strength select
// - config bit3 startup current floor
// - config bits2:0 softstart duration
// - config at 05 reset 45, level 03
// - run register at 02 reset 08
// - write applied one cycle after falling ack edge
// - undefined addresses read zero
// - answer only seven-bit address 6A
module rcr_regs (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    input  wire logic              enable_pin,
    output logic                   converter_active,
    output rcr_pkg::rcr_ctrl_t     ctrl,
    output logic [12:0]            target_mv
);
    import rcr_pkg::*;

    logic [1:0]  scl_sync_r, sda_sync_r, en_sync_r;
    logic        scl_r, sda_r;
    rcr_state_t  state_r;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  shift_r, reg_addr_r, tx_r;
    logic        rd_r, sda_oe_r;
    logic [7:0]  run_r, level_r, swcfg_r;
    logic        pend_r;
    logic [7:0]  pend_data_r;

    // synchronisers; second stage feeds logic
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            en_sync_r  <= 2'h0;
            scl_r      <= 1'b1;
            sda_r      <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
            en_sync_r  <= {en_sync_r[0], enable_pin};
            scl_r      <= scl_sync_r[1];
            sda_r      <= sda_sync_r[1];
        end
    end

    // bus events
    wire scl_s    = scl_sync_r[1];
    wire sda_s    = sda_sync_r[1];
    wire scl_rise = scl_s & ~scl_r;
    wire scl_fall = ~scl_s & scl_r;
    wire start_c  = scl_s & scl_r & sda_r & ~sda_s;
    wire stop_c   = scl_s & scl_r & ~sda_r & sda_s;
    wire [7:0] shift_nxt = {shift_r[6:0], sda_s};
    wire byte_end = scl_fall & (bit_cnt_r == 4'h8);
    wire addr_hit = (shift_r[7:1] == PERIPH_ADDR);

    // read data selection, unmapped reads zero
    wire [7:0] rd_data =
        (reg_addr_r == RUN_ADDR)   ? (run_r & RUN_WMASK) :
        (reg_addr_r == LEVEL_ADDR) ? level_r :
        (reg_addr_r == SWCFG_ADDR) ? swcfg_r : 8'h00;

    // serial peripheral state machine
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_r     <= RCR_IDLE;
            bit_cnt_r   <= 4'h0;
            shift_r     <= 8'h00;
            reg_addr_r  <= 8'h00;
            tx_r        <= 8'h00;
            rd_r        <= 1'b0;
            sda_oe_r    <= 1'b0;
            pend_r      <= 1'b0;
            pend_data_r <= 8'h00;
        end else if (start_c) begin
            state_r   <= RCR_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe_r  <= 1'b0;
        end else if (stop_c) begin
            state_r  <= RCR_IDLE;
            sda_oe_r <= 1'b0;
        end else begin
            pend_r <= 1'b0;
            if (scl_rise && bit_cnt_r < 4'h8) begin
                shift_r   <= shift_nxt;
            end
            if (scl_rise) begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            case (state_r)
                RCR_ADDR: begin
                    if (byte_end) begin
                        if (addr_hit) begin
                            state_r  <= RCR_AACK;
                            rd_r     <= shift_r[0];
                            sda_oe_r <= 1'b1;
                            tx_r     <= rd_data;
                        end else begin
                            state_r <= RCR_IDLE;
                        end
                    end
                end
                RCR_AACK, RCR_RACK, RCR_DACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        sda_oe_r  <= 1'b0;
                        if (state_r == RCR_DACK) begin
                            pend_r <= 1'b1;
                            reg_addr_r <= reg_addr_r + 8'h01;
                        end
                        if (state_r == RCR_AACK && rd_r) begin
                            state_r  <= RCR_RD;
                            sda_oe_r <= ~tx_r[7];
                        end else if (state_r == RCR_AACK) begin
                            state_r <= RCR_REG;
                        end else begin
                            state_r <= RCR_DATA;
                        end
                    end
                end
                RCR_REG: begin
                    if (byte_end) begin
                        reg_addr_r <= shift_r;
                        state_r    <= RCR_RACK;
                        sda_oe_r   <= 1'b1;
                    end
                end
                RCR_DATA: begin
                    if (byte_end) begin
                        pend_data_r <= shift_r;
                        state_r     <= RCR_DACK;
                        sda_oe_r    <= 1'b1;
                    end
                end
                RCR_RD: begin
                    if (scl_fall) begin
                        if (bit_cnt_r < 4'h8) begin
                            // bits 6..0 follow the falls after bits 7..1
                            tx_r     <= {tx_r[6:0], 1'b0};
                            sda_oe_r <= ~tx_r[6];
                        end else if (bit_cnt_r == 4'h8) begin
                            // free the line for the controller's ack
                            sda_oe_r   <= 1'b0;
                            reg_addr_r <= reg_addr_r + 8'h01;
                        end else if (sda_r) begin
                            state_r <= RCR_IDLE; // controller nack
                        end else begin
                            bit_cnt_r <= 4'h0;
                            tx_r      <= rd_data;
                            sda_oe_r  <= ~rd_data[7];
                        end
                    end
                end
                default: begin
                    state_r <= RCR_IDLE;
                end
            endcase
        end
    end

    // next-byte prefetch after ack in read mode
    // (rd_data uses the address advanced after the eighth bit)

    // register write, applied one cycle after ack falling edge
    wire wr_run   = pend_r & (reg_addr_r == RUN_ADDR + 8'h01);
    wire wr_level = pend_r & (reg_addr_r == LEVEL_ADDR + 8'h01);
    wire wr_swcfg = pend_r & (reg_addr_r == SWCFG_ADDR + 8'h01);

    // register file, set to its reset values by power-on reset
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            run_r   <= RUN_RST;
            level_r <= LEVEL_RST;
            swcfg_r <= SWCFG_RST;
        end else begin
            if (wr_run) begin
                run_r <= pend_data_r & RUN_WMASK;
            end
            if (wr_level) begin
                level_r <= pend_data_r;
            end
            if (wr_swcfg) begin
                swcfg_r <= pend_data_r;
            end
        end
    end

    // output level to millivolts
    wire [12:0] lin_mv = 13'(BASE_MV) + 13'(level_r) * 13'(STEP_MV);
    wire [12:0] mv_nxt = (level_r > LEVEL_MAX) ? SAT_MV : lin_mv;

    // registered outputs
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl             <= '0;
            converter_active <= 1'b0;
            target_mv        <= 13'd0;
        end else begin
            ctrl.converter_run <= run_r[RUN_BIT];
            converter_active   <= run_r[RUN_BIT] & en_sync_r[1];
            ctrl.quick_voltage_step_enable <= run_r[QVS_BIT];
            ctrl.hiccup_protect_enable     <= run_r[HIC_BIT];
            ctrl.forced_fixed_freq_switching <= swcfg_r[FFS_BIT];
            ctrl.fast_startup_enable   <= swcfg_r[FSU_BIT];
            ctrl.output_bleed_strength <= swcfg_r[BLEED_LO +: 2];
            ctrl.startup_current_floor <= swcfg_r[FLOOR_BIT];
            ctrl.softstart_duration_sel <= swcfg_r[SSD_LO +: 3];
            target_mv <= mv_nxt;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = sda_oe_r;
endmodule : rcr_regs

// *** tb/rcr_ctl_model.sv ***
`timescale 1ns/1ps
// serial bus controller: quarter bit of 2 clocks, released data reads high
module rcr_ctl_model (
    input  wire logic ref_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_lo
);
    // bus idles with both lines released
    initial begin
        scl = 1'b1;
        sda_lo = 1'b0;
    end
    // one quarter of a bit, changes land just after the edge
    task automatic q;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : q
    // start or repeated start: data falls while clock high
    task automatic start;
        sda_lo = 1'b0;
        q;
        scl = 1'b1;
        q;
        sda_lo = 1'b1;
        q;
        scl = 1'b0;
    endtask : start
    // stop: data rises while clock high, clock then stands still
    task automatic stop;
        sda_lo = 1'b1;
        q;
        scl = 1'b1;
        q;
        sda_lo = 1'b0;
        q;
    endtask : stop
    // nine bits msb first; bit 0 is the acknowledge slot
    task automatic xfer(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_lo = !d[i];
            q;
            scl = 1'b1;
            q;
            r[i] = sda;
            q;
            scl = 1'b0;
            q;
        end
    endtask : xfer
endmodule : rcr_ctl_model

// *** tb/rcr_regs_checker.sv ***
`timescale 1ns/1ps
// port-level checks of the register block
module rcr_regs_checker (
    input wire logic               ref_clk,
    input wire logic               reset,
    input wire logic               scl_in,
    input wire logic               sda_in,
    input wire logic               sda_out,
    input wire logic               sda_oe,
    input wire logic               enable_pin,
    input wire logic               converter_active,
    input wire rcr_pkg::rcr_ctrl_t ctrl,
    input wire logic [12:0]        target_mv
);
    import rcr_pkg::*;
    logic [1:0] live_r;
    wire        live = (live_r == 2'h3);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // counts the first edges after reset so defaults can settle
    always_ff @(posedge ref_clk or posedge reset)
        if (reset) live_r <= 2'h0;
        else if (!live) live_r <= live_r + 2'h1;
    a_open_drain: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    a_pull_clk_low: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("data pulled while clock high");
    a_free_clk_low: assert property ($fell(sda_oe) |-> !scl_in)
        else $error("data freed while clock high");
    a_pull_hold: assert property ($rose(sda_oe) |-> sda_oe[*6])
        else $error("data pull too short");
    a_level_grid: assert property (live |-> target_mv >= 13'h3E8 &&
        target_mv <= 13'h157C && (target_mv - 13'h3E8) % 13'h19 == 13'h0)
        else $error("target off the step grid");
    a_one_update: assert property (live && !$stable(target_mv)
        |-> $stable(ctrl)) else $error("two registers changed at once");
    a_pin_off: assert property (!enable_pin[*5] |-> !converter_active)
        else $error("active with enable low");
    a_run_needed: assert property (converter_active
        |-> ctrl.converter_run || $past(ctrl.converter_run))
        else $error("active without run bit");
    a_pin_on: assert property ((enable_pin && ctrl.converter_run)[*5]
        |-> converter_active) else $error("inactive with run and enable");
endmodule : rcr_regs_checker
bind rcr_regs rcr_regs_checker u_chk (.ref_clk, .reset, .scl_in, .sda_in,
    .sda_out, .sda_oe, .enable_pin, .converter_active, .ctrl, .target_mv);

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
// register block behind a modelled serial bus controller
module tb_top;
    import rcr_pkg::*;
    logic        ref_clk;
    logic        reset;
    logic        enable_pin;
    logic        sda_oe;
    logic        sda_out;
    logic        converter_active;
    rcr_ctrl_t   ctrl;
    logic [12:0] target_mv;
    wire         scl;
    wire         sda_lo;
    int          num_errors;
    int          n_compared;
    // address, written byte, expected readback
    logic [23:0] rows [10] = '{24'h02FF0D, 24'h02F200, 24'h030000,
        24'h03B4B4, 24'h03B5B5, 24'h03FFFF, 24'h055858, 24'h05A3A3,
        24'h047700, 24'h020D0D};
    logic [6:0]  bad [2] = '{7'h6B, 7'h00};
    // open-drain data wire with pull-up
    wire         sda = !(sda_lo || sda_oe);
    rcr_ctl_model m (.ref_clk, .sda, .scl, .sda_lo);
    rcr_regs dut (.ref_clk, .reset, .scl_in(scl), .sda_in(sda), .sda_out,
        .sda_oe, .enable_pin, .converter_active, .ctrl, .target_mv);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = !ref_clk;
    end
    task automatic cmp(input logic [12:0] g, input logic [12:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : cmp
    task automatic final_report;
        $display("compared %0d mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    task automatic do_reset;
        reset = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask : do_reset
    // single write: address byte, register byte, data byte, all acked
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [8:0] r;
        m.start;
        m.xfer({PERIPH_ADDR, 2'b01}, r);
        m.xfer({a, 1'b1}, r);
        m.xfer({d, 1'b1}, r);
        m.stop;
        cmp({12'h0, r[0]}, 13'h0);
    endtask : wr
    // set pointer, repeated start, read one byte and refuse more
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        logic [8:0] r;
        m.start;
        m.xfer({PERIPH_ADDR, 2'b01}, r);
        m.xfer({a, 1'b1}, r);
        m.start;
        m.xfer({PERIPH_ADDR, 2'b11}, r);
        m.xfer(9'h1FF, r);
        m.stop;
        v = r[8:1];
    endtask : rd
    task automatic chk_def;
        logic [7:0] v;
        rd(RUN_ADDR, v);
        cmp({5'h0, v}, 13'h08);
        rd(LEVEL_ADDR, v);
        cmp({5'h0, v}, 13'h5C);
        rd(SWCFG_ADDR, v);
        cmp({5'h0, v}, 13'h45);
        rd(8'h00, v);
        cmp({5'h0, v}, 13'h00);
        cmp({2'h0, ctrl}, 13'h0245);
        cmp(target_mv, 13'h0CE4);
        $display("test defaults done");
    endtask : chk_def
    initial begin
        logic [8:0] r;
        logic [7:0] v;
        logic [7:0] c;
        num_errors = 0;
        n_compared = 0;
        enable_pin = 1'b0;
        do_reset;
        chk_def;
        foreach (rows[i]) begin
            c = rows[i][15:8];
            wr(rows[i][23:16], c);
            rd(rows[i][23:16], v);
            cmp({5'h0, v}, {5'h0, rows[i][7:0]});
            if (rows[i][23:16] == LEVEL_ADDR)
                cmp(target_mv, c > 8'hB4 ? 13'h157C :
                    13'h3E8 + 13'h19 * {5'h0, c});
            if (rows[i][23:16] == RUN_ADDR)
                cmp({10'h0, ctrl[10:8]}, {10'h0, c[0], c[3:2]});
            if (rows[i][23:16] == SWCFG_ADDR)
                cmp({5'h0, ctrl[7:0]}, {5'h0, c});
        end
        cmp({2'h0, ctrl}, 13'h07A3);
        $display("test register table done");
        cmp({12'h0, converter_active}, 13'h0);
        enable_pin = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        cmp({12'h0, converter_active}, 13'h1);
        wr(RUN_ADDR, 8'h0C);
        cmp({12'h0, converter_active}, 13'h0);
        $display("test run gate done");
        foreach (bad[j]) begin
            m.start;
            m.xfer({bad[j], 2'b01}, r);
            m.stop;
            cmp({12'h0, r[0]}, 13'h1);
        end
        $display("test foreign address done");
        // two-byte write from the run register on, then two-byte read
        m.start;
        m.xfer({PERIPH_ADDR, 2'b01}, r);
        m.xfer({RUN_ADDR, 1'b1}, r);
        m.xfer(9'h013, r);
        m.xfer(9'h041, r);
        m.stop;
        m.start;
        m.xfer({PERIPH_ADDR, 2'b01}, r);
        m.xfer({RUN_ADDR, 1'b1}, r);
        m.start;
        m.xfer({PERIPH_ADDR, 2'b11}, r);
        m.xfer(9'h1FE, r);
        cmp({5'h0, r[8:1]}, 13'h09);
        m.xfer(9'h1FF, r);
        m.stop;
        cmp({5'h0, r[8:1]}, 13'h20);
        cmp(target_mv, 13'h3E8 + 13'h19 * 13'h20);
        $display("test burst done");
        do_reset;
        chk_def;
        final_report;
    end
    // cuts a hung run short
    initial begin
        repeat (100000) @(posedge ref_clk);
        num_errors++;
        $display("unexpected at %0t: run hung", $time);
        final_report;
    end
endmodule : tb_top
